/* File: hw/cppc_pkg.sv */
// Constants, register map and carrier types of the charger power path control
// Notes on behaviour
// R01: 100mA host plus good battery enters input-off
// R02: Entering input-off sets control bit 7
// R03: Host mode stays input-off until host clears
// R04: Host reads input-off indication first on wake
// R05: Default mode clears input-off on source removal
// R06: New source attach reruns current limit detection
// R07: Force bit or watchdog expiry starts detection
// R08: Limit held at 100mA during forced detection
// R09: Detection end clears force bit, applies pins
// R10: Limit set, converter on; switch follows charging
// R11: Soft-start 100mA below 2.2V, then lower limit
// R12: Boost needs all qualifiers plus 30ms delay
// R13: Boost active reports source status 11
// R14: Boost current 1A or 1.5A by bit 0
// R15: Boost voltage from four-bit code bits 7:4
// R16: Boost fault sets fault bit 6, notifies host
// R17: Minimum system voltage code, default 3.5V
// R18: Status bit 0 during minimum system regulation
// R19: Reduce charge current while input overloaded
// R20: Status bit 3 while power limiting active
// R21: Supplement on below battery, off at depletion
// R22: Config 01 at reset charges autonomously
// R23: Select and OTG pins choose detected limit
// R24: One interrupt pulse per notifying change
package cppc_pkg;

  localparam int unsigned CLOCK_MHZ = 25;
  localparam int unsigned DETECT_TIME_US = 10000;
  localparam int unsigned DETECT_CYCLES = DETECT_TIME_US * CLOCK_MHZ;
  localparam int unsigned BOOST_DELAY_US = 30000;
  localparam int unsigned BOOST_DELAY_CYCLES = BOOST_DELAY_US * CLOCK_MHZ;
  localparam int CNT_W = 20;

  // Register indices; byte address is four times the index
  localparam logic [3:0] IDX_INPUT_SOURCE_CTRL = 4'h0;
  localparam logic [3:0] IDX_CHARGE_CONFIG = 4'h1;
  localparam logic [3:0] IDX_BOOST_CTRL = 4'h6;
  localparam logic [3:0] IDX_MISC_CTRL = 4'h7;
  localparam logic [3:0] IDX_SYSTEM_STATUS = 4'h8;
  localparam logic [3:0] IDX_FAULT = 4'h9;

  // Field positions
  localparam int INPUT_OFF_BIT = 7;
  localparam int FORCE_DETECT_BIT = 7;
  localparam int BOOST_FAULT_BIT = 6;
  localparam int BOOST_CUR_BIT = 0;
  localparam int DPM_STATUS_BIT = 3;
  localparam int PGOOD_STATUS_BIT = 2;
  localparam int MINSYS_STATUS_BIT = 0;

  // Reset values
  localparam logic [7:0] RST_INPUT_SOURCE_CTRL = 8'h32;
  localparam logic [7:0] RST_CHARGE_CONFIG = 8'h1A;
  localparam logic [7:0] RST_BOOST_CTRL = 8'h70;
  localparam logic [7:0] RST_MISC_CTRL = 8'h00;

  // Charge configuration and boost control field values
  localparam logic [1:0] CFG_CHARGE = 2'h1;
  localparam logic [1:0] CFG_BOOST = 2'h2;
  localparam logic [1:0] TEMP_MON_OFF = 2'h3;

  // Input current limit codes
  localparam logic [2:0] CURRENT_LIMIT_PIN_100MA = 3'h0;
  localparam logic [2:0] CURRENT_LIMIT_PIN_500MA = 3'h2;
  localparam logic [2:0] CURRENT_LIMIT_PIN_3A = 3'h7;

  // Input source status codes
  localparam logic [1:0] SRC_NONE = 2'h0;
  localparam logic [1:0] SRC_USB_HOST = 2'h1;
  localparam logic [1:0] SRC_ADAPTER = 2'h2;
  localparam logic [1:0] SRC_BOOST = 2'h3;

  typedef enum logic [1:0] {
    PWR_IDLE = 2'b00,
    PWR_DETECT = 2'b01,
    PWR_SOFTSTART = 2'b11,
    PWR_RUN = 2'b10
  } cppc_pwr_state_t;

  // Comparator and pin levels arriving from outside the clock domain
  typedef struct packed {
    logic sourceSelect;
    logic otgPin;
    logic chargeEnableN;
    logic vbusPresent;
    logic batAboveGood;
    logic batAboveLow;
    logic vbusBelowSleep;
    logic tempInWindow;
    logic sysAbove2V2;
    logic inCurrentOver;
    logic inVoltageUnder;
    logic sysBelowBat;
    logic batBelowDepletion;
    logic sysInMinReg;
    logic boostOverVoltage;
    logic boostOverCurrent;
    logic [2:0] currentLimitPin;
  } cppc_sense_t;

  // Controls to the analog power stage
  typedef struct packed {
    logic inputOffState;
    logic biasRegulatorEn;
    logic converterEn;
    logic batterySwitchOn;
    logic [2:0] inputCurrentLimit;
    logic reduceCharge;
    logic chargeEn;
    logic boostEn;
    logic boostCurrentHigh;
    logic [3:0] boostVoltageCode;
    logic [2:0] minSysVoltageCode;
  } cppc_power_t;

endpackage

/* File: hw/cppc_power_path.sv */
// Power path sequencing, boost qualification and APB register file
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
module cppc_power_path #(
  parameter int unsigned DETECT_CYCLES = cppc_pkg::DETECT_CYCLES,
  parameter int unsigned BOOST_DELAY_CYCLES = cppc_pkg::BOOST_DELAY_CYCLES
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire cppc_pkg::cppc_sense_t senseIn,
  input wire logic hostMode,
  input wire logic watchdogExpired,
  output cppc_pkg::cppc_power_t power,
  output logic irq
);

  function automatic logic [3:0] regIndex(input logic [31:0] addr);
    regIndex = addr[5:2];
  endfunction

  function automatic logic mapped(input logic [31:0] addr);
    logic [3:0] idx;
    idx = addr[5:2];
    mapped = (addr[31:6] == 26'h0) && (addr[1:0] == 2'h0) &&
      (idx == cppc_pkg::IDX_INPUT_SOURCE_CTRL ||
       idx == cppc_pkg::IDX_CHARGE_CONFIG ||
       idx == cppc_pkg::IDX_BOOST_CTRL ||
       idx == cppc_pkg::IDX_MISC_CTRL ||
       idx == cppc_pkg::IDX_SYSTEM_STATUS ||
       idx == cppc_pkg::IDX_FAULT);
  endfunction

  cppc_pkg::cppc_sense_t senseMeta;
  cppc_pkg::cppc_sense_t sense;
  cppc_pkg::cppc_pwr_state_t state;
  logic [7:0] inputSourceCtrl;
  logic [7:0] chargeConfig;
  logic [7:0] boostCtrl;
  logic [7:0] miscCtrl;
  logic boostFault;
  logic [1:0] sourceStatus;
  logic vbusSeen;
  logic [cppc_pkg::CNT_W-1:0] detectCount;
  logic [cppc_pkg::CNT_W-1:0] boostCount;
  logic boostActive;
  logic [1:0] lastSourceStatus;
  logic lastBoostFault;

  logic wrAccess;
  logic rdAccess;
  logic [3:0] accIdx;
  logic sourceAttach;
  logic sourceRemoved;
  logic detectDone;
  logic detectStart;
  logic [2:0] detectedLimit;
  logic [1:0] detectedStatus;
  logic hundredMaHost;
  logic chargeEnabled;
  logic boostQualified;
  logic boostFaultEvent;
  logic dpmActive;
  logic [7:0] statusByte;
  logic [7:0] faultByte;
  logic [2:0] lowerLimit;

  // Levels from pins and comparators settle through two stages
  always_ff @(posedge clock) begin
    if (!resetn) begin
      senseMeta <= '0;
      sense <= '0;
    end else begin
      senseMeta <= senseIn;
      sense <= senseMeta;
    end
  end

  // APB decode; the one-cycle setup phase lets read data come from a flop
  assign pready = psel && penable;
  assign pslverr = psel && penable && !mapped(paddr);
  assign accIdx = regIndex(paddr);
  assign wrAccess = psel && penable && pwrite && mapped(paddr);
  assign rdAccess = psel && penable && !pwrite && mapped(paddr);

  assign sourceAttach = sense.vbusPresent && !vbusSeen;
  assign sourceRemoved = !sense.vbusPresent && vbusSeen;
  assign hundredMaHost = sense.sourceSelect && !sense.otgPin;

  // Detected limit from the select pin from the PHY and the OTG pin
  always_comb begin
    if (!sense.sourceSelect) begin
      detectedLimit = cppc_pkg::CURRENT_LIMIT_PIN_3A;
      detectedStatus = cppc_pkg::SRC_ADAPTER;
    end else if (sense.otgPin) begin
      detectedLimit = cppc_pkg::CURRENT_LIMIT_PIN_500MA;
      detectedStatus = cppc_pkg::SRC_USB_HOST;
    end else begin
      detectedLimit = cppc_pkg::CURRENT_LIMIT_PIN_100MA;
      detectedStatus = cppc_pkg::SRC_USB_HOST;
    end
  end // R23

  assign detectDone = (state == cppc_pkg::PWR_DETECT) &&
    (detectCount == cppc_pkg::CNT_W'(DETECT_CYCLES - 1));

  // A held input-off in host mode blocks every detection start
  assign detectStart = sense.vbusPresent &&
    !(inputSourceCtrl[cppc_pkg::INPUT_OFF_BIT] && hostMode) &&
    (sourceAttach || miscCtrl[cppc_pkg::FORCE_DETECT_BIT] ||
     watchdogExpired); // R06 R07

  always_ff @(posedge clock) begin
    if (!resetn) begin
      vbusSeen <= 1'b0;
    end else begin
      vbusSeen <= sense.vbusPresent;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      state <= cppc_pkg::PWR_IDLE;
    end else if (!sense.vbusPresent ||
                 inputSourceCtrl[cppc_pkg::INPUT_OFF_BIT]) begin
      state <= cppc_pkg::PWR_IDLE;
    end else begin
      case (state)
        cppc_pkg::PWR_IDLE: begin
          if (detectStart) begin
            state <= cppc_pkg::PWR_DETECT;
          end
        end
        cppc_pkg::PWR_DETECT: begin
          if (detectDone && !(hundredMaHost && sense.batAboveGood)) begin
            state <= cppc_pkg::PWR_SOFTSTART; // R10
          end
        end
        cppc_pkg::PWR_SOFTSTART: begin
          if (detectStart) begin
            state <= cppc_pkg::PWR_DETECT;
          end else if (sense.sysAbove2V2) begin
            state <= cppc_pkg::PWR_RUN; // R11
          end
        end
        cppc_pkg::PWR_RUN: begin
          if (detectStart) begin
            state <= cppc_pkg::PWR_DETECT;
          end
        end
        default: begin
          state <= cppc_pkg::PWR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      detectCount <= '0;
    end else if (state == cppc_pkg::PWR_DETECT && !detectDone) begin
      detectCount <= detectCount + 1'b1;
    end else begin
      detectCount <= '0;
    end
  end

  // Input source control: host writes; hardware sets and clears bit 7
  always_ff @(posedge clock) begin
    if (!resetn) begin
      inputSourceCtrl <= cppc_pkg::RST_INPUT_SOURCE_CTRL;
    end else begin
      if (wrAccess && accIdx == cppc_pkg::IDX_INPUT_SOURCE_CTRL) begin
        inputSourceCtrl <= pwdata[7:0]; // R03
      end
      if (detectDone) begin
        inputSourceCtrl[2:0] <= detectedLimit; // R06 R09
      end
      if (sourceRemoved && !hostMode) begin
        inputSourceCtrl[cppc_pkg::INPUT_OFF_BIT] <= 1'b0; // R05
      end
      // Set wins over a host clear landing in the same cycle
      if (detectDone && hundredMaHost && sense.batAboveGood) begin
        inputSourceCtrl[cppc_pkg::INPUT_OFF_BIT] <= 1'b1; // R01 R02
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      chargeConfig <= cppc_pkg::RST_CHARGE_CONFIG; // R17 R22
      boostCtrl <= cppc_pkg::RST_BOOST_CTRL;
    end else if (wrAccess) begin
      if (accIdx == cppc_pkg::IDX_CHARGE_CONFIG) begin
        chargeConfig <= pwdata[7:0];
      end
      if (accIdx == cppc_pkg::IDX_BOOST_CTRL) begin
        boostCtrl <= pwdata[7:0];
      end
    end
  end

  // Force bit drops by itself at the end; a fresh host set still wins
  always_ff @(posedge clock) begin
    if (!resetn) begin
      miscCtrl <= cppc_pkg::RST_MISC_CTRL;
    end else begin
      if (detectDone) begin
        miscCtrl[cppc_pkg::FORCE_DETECT_BIT] <= 1'b0; // R09
      end
      if (wrAccess && accIdx == cppc_pkg::IDX_MISC_CTRL) begin
        miscCtrl <= pwdata[7:0]; // R07
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      sourceStatus <= cppc_pkg::SRC_NONE;
    end else if (!sense.vbusPresent) begin
      sourceStatus <= cppc_pkg::SRC_NONE;
    end else if (detectDone) begin
      sourceStatus <= detectedStatus;
    end
  end

  // Boost qualification; the delay restarts whenever a qualifier drops
  assign boostQualified = sense.batAboveLow && sense.vbusBelowSleep &&
    sense.otgPin && chargeConfig[5:4] == cppc_pkg::CFG_BOOST &&
    (sense.tempInWindow || boostCtrl[1:0] == cppc_pkg::TEMP_MON_OFF);

  always_ff @(posedge clock) begin
    if (!resetn) begin
      boostCount <= '0;
      boostActive <= 1'b0;
    end else if (!boostQualified) begin
      boostCount <= '0;
      boostActive <= 1'b0;
    end else if (boostCount == cppc_pkg::CNT_W'(BOOST_DELAY_CYCLES - 1)) begin
      boostActive <= 1'b1; // R12
    end else begin
      boostCount <= boostCount + 1'b1;
    end
  end

  assign boostFaultEvent = boostActive &&
    (sense.boostOverVoltage || sense.boostOverCurrent);

  // Fault bit clears when read, but a fault in that cycle keeps it set
  always_ff @(posedge clock) begin
    if (!resetn) begin
      boostFault <= 1'b0;
    end else if (boostFaultEvent) begin
      boostFault <= 1'b1; // R16
    end else if (rdAccess && accIdx == cppc_pkg::IDX_FAULT) begin
      boostFault <= 1'b0;
    end
  end

  assign dpmActive = (state == cppc_pkg::PWR_RUN ||
    state == cppc_pkg::PWR_SOFTSTART) &&
    (sense.inCurrentOver || sense.inVoltageUnder);

  always_comb begin
    statusByte = 8'h00;
    statusByte[7:6] = boostActive ? cppc_pkg::SRC_BOOST : sourceStatus; // R13
    statusByte[cppc_pkg::DPM_STATUS_BIT] = dpmActive; // R20
    statusByte[cppc_pkg::PGOOD_STATUS_BIT] = sense.vbusPresent;
    statusByte[cppc_pkg::MINSYS_STATUS_BIT] = sense.sysInMinReg; // R18
    faultByte = 8'h00;
    faultByte[cppc_pkg::BOOST_FAULT_BIT] = boostFault;
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (regIndex(paddr))
        cppc_pkg::IDX_INPUT_SOURCE_CTRL: prdata <= {24'h0, inputSourceCtrl};
        cppc_pkg::IDX_CHARGE_CONFIG: prdata <= {24'h0, chargeConfig};
        cppc_pkg::IDX_BOOST_CTRL: prdata <= {24'h0, boostCtrl};
        cppc_pkg::IDX_MISC_CTRL: prdata <= {24'h0, miscCtrl};
        cppc_pkg::IDX_SYSTEM_STATUS: prdata <= {24'h0, statusByte};
        cppc_pkg::IDX_FAULT: prdata <= {24'h0, faultByte};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // One pulse per change of reported source status or new boost fault
  always_ff @(posedge clock) begin
    if (!resetn) begin
      lastSourceStatus <= cppc_pkg::SRC_NONE;
      lastBoostFault <= 1'b0;
      irq <= 1'b0;
    end else begin
      lastSourceStatus <= statusByte[7:6];
      lastBoostFault <= boostFault;
      irq <= (statusByte[7:6] != lastSourceStatus) ||
        (boostFault && !lastBoostFault); // R24 R16
    end
  end

  assign chargeEnabled = chargeConfig[5:4] == cppc_pkg::CFG_CHARGE &&
    !sense.chargeEnableN; // R22

  assign lowerLimit = (inputSourceCtrl[2:0] < sense.currentLimitPin) ?
    inputSourceCtrl[2:0] : sense.currentLimitPin;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      power <= '0;
    end else begin
      power.inputOffState <= inputSourceCtrl[cppc_pkg::INPUT_OFF_BIT]; // R01
      power.biasRegulatorEn <= sense.vbusPresent &&
        !inputSourceCtrl[cppc_pkg::INPUT_OFF_BIT];
      power.converterEn <= state == cppc_pkg::PWR_SOFTSTART ||
        state == cppc_pkg::PWR_RUN; // R10
      if (state == cppc_pkg::PWR_RUN) begin
        power.inputCurrentLimit <= lowerLimit; // R11
      end else begin
        power.inputCurrentLimit <= cppc_pkg::CURRENT_LIMIT_PIN_100MA; // R08 R11
      end
      // Supplement overrides a disabled charge; depletion always opens it
      if (sense.batBelowDepletion) begin
        power.batterySwitchOn <= 1'b0; // R21
      end else if (sense.sysBelowBat) begin
        power.batterySwitchOn <= 1'b1; // R21
      end else if (state == cppc_pkg::PWR_SOFTSTART ||
                   state == cppc_pkg::PWR_RUN) begin
        power.batterySwitchOn <= chargeEnabled; // R10
      end else begin
        power.batterySwitchOn <= 1'b1;
      end
      power.reduceCharge <= dpmActive; // R19
      power.chargeEn <= chargeEnabled && state == cppc_pkg::PWR_RUN;
      power.boostEn <= boostActive; // R12
      power.boostCurrentHigh <= chargeConfig[cppc_pkg::BOOST_CUR_BIT]; // R14
      power.boostVoltageCode <= boostCtrl[7:4]; // R15
      power.minSysVoltageCode <= chargeConfig[3:1]; // R17
    end
  end

endmodule

/* File: verif/cppc_analog_model.sv */
// Behavioural power stage: system rail ramp after converter start
`timescale 1ns/1ps
module cppc_analog_model #(
  parameter int RAMP = 6
) (
  input wire logic clock,
  input wire logic slow,
  input wire cppc_pkg::cppc_power_t power,
  output logic sysUp
);
  int cnt = 0;
  // Rail climbs only while switching; a heavy load doubles the ramp
  always @(posedge clock) begin
    if (power.converterEn !== 1'h1) begin
      cnt <= 0;
      sysUp <= 1'h0;
    end else begin
      cnt <= cnt + 1;
      sysUp <= cnt >= (slow ? 2 * RAMP : RAMP);
    end
  end
endmodule

/* File: verif/cppc_power_path_properties.sv */
// Assertion checker bound to the power path controller
`timescale 1ns/1ps
module cppc_power_path_properties #(
  parameter int unsigned DETECT_CYCLES = 8,
  parameter int unsigned BOOST_DELAY_CYCLES = 16
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire cppc_pkg::cppc_sense_t senseIn,
  input wire logic hostMode,
  input wire logic watchdogExpired,
  input wire cppc_pkg::cppc_power_t power,
  input wire logic irq
);
  logic [2:0] upCnt;
  logic warm;
  logic over;
  logic bFault;
  logic dep;
  logic sysLow;
  assign warm = upCnt == 3'h7;
  assign over = senseIn.inCurrentOver | senseIn.inVoltageUnder;
  assign bFault = senseIn.boostOverCurrent | senseIn.boostOverVoltage;
  assign dep = senseIn.batBelowDepletion;
  assign sysLow = senseIn.sysBelowBat;
  // Sense inputs lag three edges; hold off until the pipe is flushed
  always_ff @(posedge clock) begin
    if (!resetn) begin
      upCnt <= 3'h0;
    end else if (!warm) begin
      upCnt <= upCnt + 3'h1;
    end
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  sequence s_depleted;
    $past(dep, 3) && $past(dep, 4);
  endsequence
  sequence s_supplied;
    $past(sysLow, 3) && $past(sysLow, 4) && !$past(dep, 3) && !$past(dep, 4);
  endsequence
  sequence s_qualified;
    $past(senseIn.otgPin, 5) && $past(senseIn.batAboveLow, 5)
      && !$past(power.boostEn, BOOST_DELAY_CYCLES);
  endsequence
  property p_off_quiet;
    power.inputOffState [*2] |-> !power.biasRegulatorEn && !power.converterEn;
  endproperty
  property p_soft_limit;
    !power.converterEn |-> power.inputCurrentLimit == cppc_pkg::CURRENT_LIMIT_PIN_100MA;
  endproperty
  property p_boost_qual;
    $rose(power.boostEn) |-> s_qualified;
  endproperty
  property p_boost_irq;
    $rose(power.boostEn) |-> irq;
  endproperty
  property p_irq_pulse;
    irq |=> !irq;
  endproperty
  property p_fault_irq;
    power.boostEn && $rose(bFault) |-> ##[2:6] irq;
  endproperty
  property p_reduce;
    warm && power.converterEn && $past(power.converterEn)
      && $past(over, 3) == $past(over, 4)
      |-> power.reduceCharge == $past(over, 3);
  endproperty
  property p_deplete;
    warm ##0 s_depleted |-> !power.batterySwitchOn;
  endproperty
  property p_supply;
    warm ##0 s_supplied |-> power.batterySwitchOn;
  endproperty
  a_off_quiet: assert property (p_off_quiet)
    else $error("bias or converter on while input off");
  a_soft_limit: assert property (p_soft_limit)
    else $error("limit not 100mA with converter off");
  a_boost_qual: assert property (p_boost_qual)
    else $error("boost enabled early or unqualified");
  a_boost_irq: assert property (p_boost_irq)
    else $error("no interrupt on boost entry");
  a_irq_pulse: assert property (p_irq_pulse)
    else $error("interrupt longer than one cycle");
  a_fault_irq: assert property (p_fault_irq)
    else $error("no interrupt on boost fault");
  a_reduce: assert property (p_reduce)
    else $error("charge reduction does not follow overload");
  a_deplete: assert property (p_deplete)
    else $error("battery switch on while depleted");
  a_supply: assert property (p_supply)
    else $error("battery switch off in supplement");
endmodule

bind cppc_power_path cppc_power_path_properties #(
  .DETECT_CYCLES(DETECT_CYCLES),
  .BOOST_DELAY_CYCLES(BOOST_DELAY_CYCLES)
) cppc_power_path_properties_i (
  .clock(clock), .resetn(resetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .senseIn(senseIn),
  .hostMode(hostMode), .watchdogExpired(watchdogExpired), .power(power),
  .irq(irq)
);

/* File: verif/charger_power_path_control_test.sv */
// Self-checking bench of the charger power path controller
`timescale 1ns/1ps
module charger_power_path_control_test;
  localparam int DET = 8;
  logic clock = 1'h0;
  logic resetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic hostMode = 1'h0;
  logic watchdogExpired = 1'h0;
  logic slow = 1'h0;
  logic sysUp;
  logic irq;
  logic se;
  logic off;
  logic [2:0] lim;
  logic [31:0] rd;
  logic [31:0] r;
  logic [31:0] seed = 32'h4B589916;
  cppc_pkg::cppc_sense_t sense = '0;
  cppc_pkg::cppc_sense_t senseIn;
  cppc_pkg::cppc_power_t power;
  int err_count = 0;
  int n_compared = 0;
  int cyc = 0;

  always #20 clock = ~clock;
  always_comb begin
    senseIn = sense;
    senseIn.sysAbove2V2 = sysUp;
  end

  cppc_power_path #(.DETECT_CYCLES(DET), .BOOST_DELAY_CYCLES(16))
    cppc_power_path_i (.clock(clock), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .senseIn(senseIn),
    .hostMode(hostMode), .watchdogExpired(watchdogExpired), .power(power),
    .irq(irq));
  cppc_analog_model cppc_analog_model_i (.clock(clock), .slow(slow),
    .power(power), .sysUp(sysUp));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [2:0] expLimit(input logic sel, otg);
    if (!sel) return cppc_pkg::CURRENT_LIMIT_PIN_3A;
    return otg ? cppc_pkg::CURRENT_LIMIT_PIN_500MA : cppc_pkg::CURRENT_LIMIT_PIN_100MA;
  endfunction

  task automatic end_of_test();
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Waits for pready however long; only the bench timeout ends a hang
  task automatic apb(input logic wr, input logic [31:0] a, d);
    @(posedge clock);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    do begin
      @(posedge clock);
    end while (pready !== 1'h1);
    rd = prdata;
    se = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic rdChk(input string nm, input logic [31:0] a, exp);
    apb(1'h0, a, 32'h0);
    chk(nm, rd, exp);
  endtask

  task automatic plug(input logic sel, otg);
    r = rnd();
    @(posedge clock);
    sense.sourceSelect <= sel;
    sense.otgPin <= otg;
    sense.batAboveGood <= 1'h1;
    sense.currentLimitPin <= r[2:0];
    slow <= r[3];
    sense.vbusPresent <= 1'h1;
    repeat (DET + 24) @(posedge clock);
  endtask

  task automatic extras();
    sense.chargeEnableN <= 1'h1;
    repeat (6) @(posedge clock);
    chk("noChargeSwitch", power.batterySwitchOn, 1'h0);
    sense.chargeEnableN <= 1'h0;
    sense.sysBelowBat <= 1'h1;
    repeat (6) @(posedge clock);
    chk("supplement", power.batterySwitchOn, 1'h1);
    sense.batBelowDepletion <= 1'h1;
    repeat (6) @(posedge clock);
    chk("depleted", power.batterySwitchOn, 1'h0);
    sense.sysBelowBat <= 1'h0;
    sense.batBelowDepletion <= 1'h0;
    for (int k = 3; k >= 0; k--) begin
      sense.inCurrentOver <= k[0];
      sense.inVoltageUnder <= k[1];
      sense.sysInMinReg <= k[0];
      repeat (6) @(posedge clock);
      chk("reduce", power.reduceCharge, k != 0);
      rdChk("dpm", 32'h20, 32'h84 | (k != 0 ? 32'h8 : 32'h0) | k[0]);
    end
    sense.sourceSelect <= 1'h1;
    sense.otgPin <= 1'h1;
    apb(1'h1, 32'h1C, 32'h80);
    repeat (3) @(posedge clock);
    chk("forcedLimit", power.inputCurrentLimit, 3'h0);
    rdChk("forceBusy", 32'h1C, 32'h80);
    repeat (DET + 24) @(posedge clock);
    rdChk("forceDone", 32'h1C, 32'h0);
    rdChk("forcedResult", 32'h0, 32'h32);
    sense.sourceSelect <= 1'h0;
    sense.otgPin <= 1'h0;
    watchdogExpired <= 1'h1;
    @(posedge clock);
    watchdogExpired <= 1'h0;
    repeat (DET + 24) @(posedge clock);
    rdChk("watchdogResult", 32'h0, 32'h37);
  endtask

  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      err_count++;
      end_of_test();
    end
  end

  initial begin
    repeat (20) @(posedge clock);
    resetn <= 1'h1;
    rdChk("ctrlReset", 32'h0, 32'h32);
    rdChk("configReset", 32'h4, 32'h1A);
    rdChk("boostReset", 32'h18, 32'h70);
    rdChk("miscReset", 32'h1C, 32'h0);
    chk("minSysCode", power.minSysVoltageCode, 3'h5);
    apb(1'h0, 32'h40, 32'h0);
    chk("unmapped", se, 1'h1);
    for (int i = 0; i < 4; i++) begin
      plug(i[1], i[0]);
      off = i[1] & ~i[0];
      lim = expLimit(i[1], i[0]);
      rdChk("ctrlDetect", 32'h0, {24'h0, off, 4'h6, lim});
      rdChk("srcStatus", 32'h20, i[1] ? 32'h44 : 32'h84);
      chk("offState", power.inputOffState, off);
      if (!off) begin
        chk("chargeEn", power.chargeEn, 1'h1);
        chk("switchOn", power.batterySwitchOn, 1'h1);
        r = lim < sense.currentLimitPin ? lim : sense.currentLimitPin;
        chk("runLimit", power.inputCurrentLimit, r[2:0]);
      end
      if (i == 0) extras();
      @(posedge clock);
      sense.vbusPresent <= 1'h0;
      repeat (8) @(posedge clock);
      rdChk("offCleared", 32'h0, {24'h0, 1'h0, 4'h6, lim});
    end
    hostMode <= 1'h1;
    plug(1'h1, 1'h0);
    sense.vbusPresent <= 1'h0;
    repeat (8) @(posedge clock);
    rdChk("hostKeepsOff", 32'h0, 32'hB0);
    apb(1'h1, 32'h0, 32'h32);
    rdChk("hostCleared", 32'h0, 32'h32);
    hostMode <= 1'h0;
    sense.vbusBelowSleep <= 1'h1;
    sense.batAboveLow <= 1'h1;
    sense.otgPin <= 1'h1;
    sense.tempInWindow <= 1'h1;
    r = rnd();
    apb(1'h1, 32'h18, {24'h0, r[7:4], 4'h0});
    apb(1'h1, 32'h4, 32'h2B);
    repeat (8) @(posedge clock);
    chk("boostEarly", power.boostEn, 1'h0);
    repeat (20) @(posedge clock);
    chk("boostOn", power.boostEn, 1'h1);
    rdChk("boostSrc", 32'h20, 32'hC0);
    chk("boost1A5", power.boostCurrentHigh, 1'h1);
    chk("boostVolt", power.boostVoltageCode, r[7:4]);
    apb(1'h1, 32'h4, 32'h2A);
    repeat (4) @(posedge clock);
    chk("boost1A", power.boostCurrentHigh, 1'h0);
    sense.boostOverCurrent <= 1'h1;
    repeat (6) @(posedge clock);
    rdChk("boostFault", 32'h24, 32'h40);
    sense.boostOverCurrent <= 1'h0;
    repeat (4) @(posedge clock);
    // The earlier read saw the fault still present, so the bit held
    rdChk("faultSticky", 32'h24, 32'h40);
    rdChk("faultCleared", 32'h24, 32'h0);
    end_of_test();
  end
endmodule
